/* File: rtl/tws_regs.svh */
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
// Clock period in ns and write-cycle times in us
`define TWS_CLK_NS 40
`define TWS_TWR_TYP_US 5000
`define TWS_TWR_MAX_US 10000
`define TWS_TWR_CYC ((`TWS_TWR_TYP_US * 1000) / `TWS_CLK_NS)
// Bus clock: half period of the master's serial clock, in us
`define TWS_HALF_US 5
`define TWS_HALF_CYC (((`TWS_HALF_US * 1000) + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_ADDR_W 7
`define TWS_DATA_W 8
`define TWS_PAGE_LO 2
`define TWS_BITS 8
`endif

/* File: rtl/tws_pkg.sv */
`default_nettype none
package tws_pkg;
  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_ADDR = 3'b001,
    TWS_AACK = 3'b011,
    TWS_WDAT = 3'b010,
    TWS_WACK = 3'b110,
    TWS_RDAT = 3'b111,
    TWS_RACK = 3'b101
  } tws_dev_state_type;
  typedef enum logic [2:0] {
    TWM_IDLE = 3'b000,
    TWM_STA = 3'b001,
    TWM_BIT = 3'b011,
    TWM_ACK = 3'b010,
    TWM_STO = 3'b110,
    TWM_DONE = 3'b111
  } tws_mst_state_type;
endpackage
`default_nettype wire

/* File: rtl/tws_bus_if.sv */
`default_nettype none
interface tws_bus_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));
  modport dev(input scl, input sda, output sda_d_o, output sda_d_oe);
  modport mst(output scl, input sda, output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

/* File: rtl/tws_mem.sv */
`default_nettype none
`include "tws_regs.svh"
module tws_mem #(
  parameter int AW = `TWS_ADDR_W,
  parameter int DW = `TWS_DATA_W
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [2**AW];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end
  assign rdata_o = mem_q[raddr_i];
endmodule
`default_nettype wire

/* File: rtl/tws_dev.sv */
// Notes on behaviour
// - Start is data falling while clock high
// - Stop is data rising; returns standby
// - Data changes only while clock low
// - Ninth clock: receiver pulls data low
// - First byte: seven-bit address, direction bit
// - Acknowledge every received write byte
// - Read: send byte, continue only on acknowledge
// - Master sends stop after no acknowledge
// - Stop after write data starts programming
// - No response while programming
// - Page is upper five bits, four bytes
// - Write increments low two bits, wraps
// - Polling: acknowledge withheld while busy
// - Direction one selects read
// - Master ends read with stop or nack
// - Read address wraps 127 to zero
// - Array of 128 bytes of 8 bits
// - Stop only after data released
// - Slave only, never drives clock
// - Programming done within 10 ms
`default_nettype none
`include "tws_regs.svh"
module tws_dev
  import tws_pkg::*;
#(
  parameter int AW = `TWS_ADDR_W,
  parameter int DW = `TWS_DATA_W,
  parameter int PAGE = 1 << `TWS_PAGE_LO,
  parameter int TWR_CYC = `TWS_TWR_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  tws_bus_if.dev bus,
  output logic busy_o
);
  import tws_pkg::*;
  localparam int PLW = $clog2(PAGE);
  localparam int CW = $clog2(TWR_CYC + 1);
  initial begin
    if (AW + 1 != `TWS_BITS || DW != `TWS_BITS || PLW < 1 || PLW >= AW) begin
      $error("tws_dev: unsupported widths");
    end
    if (TWR_CYC > (`TWS_TWR_MAX_US * 1000) / `TWS_CLK_NS) begin
      $error("tws_dev: write cycle too long");
    end
  end

  tws_dev_state_type st_q, st_d;
  logic scl_q, sda_q;
  logic [2:0] bit_q, bit_d;
  logic [DW-1:0] sh_q, sh_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] page_q [PAGE];
  logic [PAGE-1:0] pv_q, pv_d;
  logic [AW-1:0] pbase_q, pbase_d;
  logic prog_q, prog_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [PLW-1:0] pidx_q, pidx_d;
  logic oe_q, oe_d;
  logic arm_q, arm_d;
  logic pw_en;
  logic [PLW-1:0] pw_idx;
  logic [DW-1:0] rdata;
  logic mem_we;
  logic [AW-1:0] mem_wa;

  wire start_w = scl_q && bus.scl && sda_q && !bus.sda;
  wire stop_w = scl_q && bus.scl && !sda_q && bus.sda;
  wire rise_w = !scl_q && bus.scl;
  wire fall_w = scl_q && !bus.scl;

  tws_mem #(.AW(AW), .DW(DW)) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(mem_wa),
    .wdata_i(page_q[pidx_q]),
    .raddr_i(addr_q),
    .rdata_o(rdata)
  );

  assign bus.sda_d_o = 1'b0;
  assign bus.sda_d_oe = oe_q;
  assign busy_o = prog_q;
  assign mem_we = prog_q && pv_q[pidx_q];
  assign mem_wa = {pbase_q[AW-1:PLW], pidx_q};

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    addr_d = addr_q;
    pv_d = pv_q;
    pbase_d = pbase_q;
    prog_d = prog_q;
    cnt_d = cnt_q;
    pidx_d = pidx_q;
    oe_d = oe_q;
    arm_d = arm_q;
    pw_en = 1'b0;
    pw_idx = addr_q[PLW-1:0];
    if (prog_q) begin
      st_d = TWS_IDLE;
      oe_d = 1'b0;
      pidx_d = pidx_q + 1'b1;
      if (cnt_q == '0) begin
        prog_d = 1'b0;
        pv_d = '0;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end else if (stop_w) begin
      st_d = TWS_IDLE;
      oe_d = 1'b0;
      if (pv_q != '0) begin
        prog_d = 1'b1;
        cnt_d = CW'(TWR_CYC - 1);
        pidx_d = '0;
      end
    end else if (start_w) begin
      st_d = TWS_ADDR;
      bit_d = '0;
      oe_d = 1'b0;
      pv_d = '0;
      arm_d = 1'b0;
    end else begin
      unique case (st_q)
        TWS_IDLE: begin
          oe_d = 1'b0;
        end
        TWS_ADDR, TWS_WDAT: begin
          if (rise_w) begin
            sh_d = {sh_q[DW-2:0], bus.sda};
            arm_d = 1'b1;
          end
          // act on falling clock
          // The start's own clock fall comes before any bit, so it must not count
          if (fall_w && arm_q) begin
            bit_d = bit_q + 1'b1;
            if (bit_q == 3'h7) begin
              oe_d = 1'b1;
              st_d = (st_q == TWS_ADDR) ? TWS_AACK : TWS_WACK;
              if (st_q == TWS_WDAT) begin
                pw_en = 1'b1;
                pv_d[addr_q[PLW-1:0]] = 1'b1;
                pbase_d = addr_q;
                addr_d = {addr_q[AW-1:PLW], addr_q[PLW-1:0] + 1'b1};
              end else begin
                addr_d = sh_q[DW-1:1];
              end
            end
          end
        end
        TWS_AACK: begin
          if (fall_w) begin
            if (sh_q[0]) begin
              st_d = TWS_RDAT;
              sh_d = rdata;
              oe_d = !rdata[DW-1];
              bit_d = 3'h1;
            end else begin
              st_d = TWS_WDAT;
              oe_d = 1'b0;
              bit_d = '0;
            end
          end
        end
        TWS_WACK: begin
          if (fall_w) begin
            st_d = TWS_WDAT;
            oe_d = 1'b0;
          end
        end
        TWS_RDAT: begin
          if (fall_w) begin
            bit_d = bit_q + 1'b1;
            if (bit_q == '0) begin
              oe_d = 1'b0;
              st_d = TWS_RACK;
              addr_d = addr_q + 1'b1;
            end else begin
              oe_d = !sh_q[DW - 1 - bit_q];
            end
          end
        end
        TWS_RACK: begin
          if (rise_w) begin
            st_d = bus.sda ? TWS_IDLE : TWS_RACK;
            sh_d = rdata;
          end
          if (fall_w) begin
            st_d = TWS_RDAT;
            oe_d = !sh_q[DW-1];
            bit_d = 3'h1;
          end
        end
        default: st_d = TWS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (pw_en) begin
      page_q[pw_idx] <= sh_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= TWS_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_q <= '0;
      sh_q <= '0;
      addr_q <= '0;
      pv_q <= '0;
      pbase_q <= '0;
      prog_q <= 1'b0;
      cnt_q <= '0;
      pidx_q <= '0;
      oe_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      st_q <= st_d;
      scl_q <= bus.scl;
      sda_q <= bus.sda;
      bit_q <= bit_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      pv_q <= pv_d;
      pbase_q <= pbase_d;
      prog_q <= prog_d;
      cnt_q <= cnt_d;
      pidx_q <= pidx_d;
      oe_q <= oe_d;
      arm_q <= arm_d;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/tws_mst.sv */
`default_nettype none
`include "tws_regs.svh"
module tws_mst
  import tws_pkg::*;
#(
  parameter int HALF_CYC = `TWS_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  tws_bus_if.mst bus,
  input wire logic req_i,
  input wire logic [7:0] hdr_i,
  input wire logic [7:0] wdata_i,
  input wire logic last_i,
  output logic ready_o,
  output logic byte_vld_o,
  output logic [7:0] rdata_o,
  output logic nack_o,
  output logic done_o
);
  import tws_pkg::*;
  localparam int HW = $clog2(HALF_CYC + 1);
  initial begin
    if (HALF_CYC < 2) begin
      $error("tws_mst: half period too short");
    end
  end
  tws_mst_state_type st_q, st_d;
  logic [HW-1:0] div_q, div_d;
  logic ph_q, ph_d;
  logic scl_q, scl_d, sdo_q, sdo_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic rd_q, rd_d, first_q, first_d, lastb_q, lastb_d;
  logic vld_q, vld_d, nack_q, nack_d, done_q, done_d;
  logic [7:0] rx_q, rx_d;
  wire tick = div_q == '0;

  assign bus.scl = scl_q;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = !sdo_q;
  assign ready_o = st_q == TWM_IDLE;
  assign byte_vld_o = vld_q;
  assign rdata_o = rx_q;
  assign nack_o = nack_q;
  assign done_o = done_q;

  always_comb begin
    st_d = st_q;
    div_d = tick ? HW'(HALF_CYC - 1) : div_q - 1'b1;
    ph_d = ph_q;
    scl_d = scl_q;
    sdo_d = sdo_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rd_d = rd_q;
    first_d = first_q;
    lastb_d = lastb_q;
    vld_d = 1'b0;
    nack_d = 1'b0;
    done_d = 1'b0;
    rx_d = rx_q;
    unique case (st_q)
      TWM_IDLE: begin
        if (req_i) begin
          st_d = TWM_STA;
          sh_d = hdr_i;
          rd_d = hdr_i[0];
          first_d = 1'b1;
          lastb_d = last_i;
          div_d = HW'(HALF_CYC - 1);
        end
      end
      TWM_STA: if (tick) begin
        sdo_d = 1'b0;
        st_d = TWM_BIT;
        bit_d = '0;
        ph_d = 1'b0;
      end
      TWM_BIT: if (tick) begin
        ph_d = !ph_q;
        if (!ph_q) begin
          scl_d = 1'b0;
        end else if (scl_q) begin
          scl_d = 1'b0;
        end
        if (ph_q && !scl_q) begin
          scl_d = 1'b1;
          rx_d = {rx_q[6:0], bus.sda};
        end else if (!ph_q) begin
          if (bit_q == 4'h8) begin
            st_d = TWM_ACK;
            sdo_d = !(rd_q && !first_q) || lastb_q;
          end else begin
            sdo_d = (rd_q && !first_q) ? 1'b1 : sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
            bit_d = bit_q + 1'b1;
          end
        end
      end
      TWM_ACK: if (tick) begin
        ph_d = !ph_q;
        if (ph_q && !scl_q) begin
          scl_d = 1'b1;
          if (!(rd_q && !first_q) && bus.sda) begin
            nack_d = 1'b1;
            lastb_d = 1'b1;
          end
        end else if (!ph_q && scl_q) begin
          scl_d = 1'b0;
          vld_d = rd_q && !first_q;
          first_d = 1'b0;
          bit_d = '0;
          // Next byte opens in the low phase with data released; its first bit goes out on the next tick, like the first byte
          ph_d = 1'b0;
          st_d = lastb_q ? TWM_STO : TWM_BIT;
          sdo_d = lastb_q ? 1'b0 : 1'b1;
          sh_d = wdata_i;
          lastb_d = last_i;
        end
      end
      TWM_STO: if (tick) begin
        if (!scl_q) begin
          scl_d = 1'b1;
        end else begin
          sdo_d = 1'b1;
          st_d = TWM_DONE;
        end
      end
      TWM_DONE: if (tick) begin
        done_d = 1'b1;
        st_d = TWM_IDLE;
      end
      default: st_d = TWM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= TWM_IDLE;
      div_q <= '0;
      ph_q <= 1'b0;
      scl_q <= 1'b1;
      sdo_q <= 1'b1;
      bit_q <= '0;
      sh_q <= '0;
      rd_q <= 1'b0;
      first_q <= 1'b0;
      lastb_q <= 1'b0;
      vld_q <= 1'b0;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      rx_q <= '0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      scl_q <= scl_d;
      sdo_q <= sdo_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      first_q <= first_d;
      lastb_q <= lastb_d;
      vld_q <= vld_d;
      nack_q <= nack_d;
      done_q <= done_d;
      rx_q <= rx_d;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tws_chk.sv */
`default_nettype none
module tws_chk #(
  parameter int TWR_CYC = 125000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic busy_o
);
  logic scl_q, sda_q, act_q, act_d, rw_q, rw_d, nak_q, nak_d, bsy_q, bsy_d;
  logic [3:0] bit_q, bit_d, unit_q, unit_d;
  logic [31:0] cnt_q, cnt_d;
  logic rise, start, stop;
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  // Framing is tracked from the wire alone, so a wrong device state cannot hide itself
  always_comb begin
    bit_d = bit_q;
    unit_d = unit_q;
    rw_d = rw_q;
    nak_d = nak_q;
    act_d = (act_q || start) && !stop;
    bsy_d = bsy_q || busy_o;
    cnt_d = busy_o ? cnt_q + 32'h1 : 32'h0;
    if (start || stop) begin
      bit_d = 4'h0;
      unit_d = 4'h0;
      nak_d = 1'b0;
      bsy_d = busy_o;
    end else if (rise) begin
      bit_d = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      if (bit_q == 4'h8 && unit_q != 4'hf) unit_d = unit_q + 4'h1;
      if (bit_q == 4'h7 && unit_q == 4'h0) rw_d = sda;
      if (bit_q == 4'h8 && unit_q != 4'h0 && rw_q && sda) nak_d = 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {scl_q, sda_q} <= 2'h3;
      {act_q, rw_q, nak_q, bsy_q} <= 4'h0;
      bit_q <= 4'h0;
      unit_q <= 4'h0;
      cnt_q <= 32'h0;
    end else begin
      {scl_q, sda_q} <= {scl, sda};
      {act_q, rw_q, nak_q, bsy_q} <= {act_d, rw_d, nak_d, bsy_d};
      bit_q <= bit_d;
      unit_q <= unit_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_ninth;
    rise && bit_q == 4'h8;
  endsequence
  chk_idle_quiet: assert property (!act_q && !start |-> !sda_d_oe)
    else $error("device drove data outside a frame");
  chk_oe_scl_low: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device changed data while clock high");
  chk_open_drain: assert property (sda_d_oe |-> !sda_d_o)
    else $error("device drove data high");
  chk_hdr_ack: assert property (s_ninth ##0 (unit_q == 4'h0 && !bsy_q && !busy_o) |-> !sda)
    else $error("no acknowledge of first byte");
  chk_wr_ack: assert property (s_ninth ##0 (unit_q != 4'h0 && !rw_q && !bsy_q) |-> !sda)
    else $error("no acknowledge of write byte");
  chk_rd_release: assert property (s_ninth ##0 (unit_q != 4'h0 && rw_q) |-> !sda_d_oe)
    else $error("device held data in read acknowledge slot");
  chk_nak_quiet: assert property (nak_q |-> !sda_d_oe)
    else $error("device sent on after no acknowledge");
  chk_busy_quiet: assert property (busy_o |-> !sda_d_oe)
    else $error("device answered while programming");
  chk_prog_start: assert property (stop && !rw_q && unit_q >= 4'h2 && !bsy_q |-> ##[1:3] busy_o)
    else $error("programming did not start after stop");
  chk_no_prog: assert property (stop && unit_q == 4'h1 && !busy_o |=> !busy_o [*4])
    else $error("programming started without data");
  chk_prog_len: assert property ($fell(busy_o) |-> cnt_q == TWR_CYC)
    else $error("programming length wrong");
endmodule
`default_nettype wire

/* File: dv/tws_tb.sv */
`default_nettype none
module tws_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TWR = 150;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  logic [7:0] hdr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic last_i = 1'b0;
  logic ready_o, byte_vld_o, nack_o, done_o, busy_o, got_nack;
  logic [7:0] rdata_o;
  logic [7:0] wbuf [8];
  logic [7:0] rbuf [$];
  int fail_count = 0;
  int samples_checked = 0;
  tws_bus_if bus ();
  always #20 clk_i = ~clk_i;
  tws_dev #(.TWR_CYC(TWR)) tws_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
    .busy_o(busy_o));
  tws_mst #(.HALF_CYC(4)) tws_mst_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
    .req_i(req_i), .hdr_i(hdr_i), .wdata_i(wdata_i), .last_i(last_i), .ready_o(ready_o),
    .byte_vld_o(byte_vld_o), .rdata_o(rdata_o), .nack_o(nack_o), .done_o(done_o));
  tws_chk #(.TWR_CYC(TWR)) tws_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl(bus.scl),
    .sda(bus.sda), .sda_d_o(bus.sda_d_o), .sda_d_oe(bus.sda_d_oe), .busy_o(busy_o));
  // Pulses stand one cycle; the falling edge sees them settled
  always @(negedge clk_i) begin
    if (byte_vld_o === 1'b1) rbuf.push_back(rdata_o);
    if (nack_o === 1'b1) got_nack = 1'b1;
  end
  task test_done();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task fill(input logic [7:0] base);
    for (int i = 0; i < 8; i++) wbuf[i] = base + 8'(i);
  endtask
  // Next byte and its last flag are placed at each ninth clock, before the master samples them
  task xfer(input logic [7:0] hdr, input int n);
    int u, bits, t;
    logic p;
    u = 0;
    bits = 0;
    t = 0;
    p = 1'b1;
    rbuf.delete();
    got_nack = 1'b0;
    @(posedge clk_i);
    hdr_i <= hdr;
    wdata_i <= wbuf[0];
    last_i <= (n == 0);
    req_i <= 1'b1;
    @(negedge clk_i);
    while (ready_o !== 1'b1 && t < 1000) begin
      @(negedge clk_i);
      t++;
    end
    @(posedge clk_i);
    req_i <= 1'b0;
    while (done_o !== 1'b1 && t < 20000) begin
      @(negedge clk_i);
      t++;
      if (bus.scl === 1'b1 && p === 1'b0) bits++;
      p = bus.scl;
      if (bits == 9) begin
        bits = 0;
        @(posedge clk_i);
        wdata_i <= wbuf[u];
        last_i <= (u + 1 == n);
        u++;
      end
    end
    if (t >= 20000) begin
      fail_count++;
      $display("transfer did not finish");
      test_done();
    end
  endtask
  task wr(input logic [6:0] a, input int n);
    int k;
    xfer({a, 1'b0}, n);
    check({7'h00, got_nack}, 8'h00);
    xfer({a, 1'b0}, 0);
    check({7'h00, got_nack}, 8'h01);
    k = 0;
    while (got_nack === 1'b1 && k < 8) begin
      xfer({a, 1'b0}, 0);
      k++;
    end
    check({7'h00, got_nack}, 8'h00);
  endtask
  task rd(input logic [6:0] a, input int n);
    xfer({a, 1'b1}, n);
    check(8'(rbuf.size()), 8'(n));
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    fill(8'h10);
    wr(7'h08, 4);
    rd(7'h08, 4);
    for (int i = 0; i < 4; i++) check(rbuf[i], 8'h10 + 8'(i));
    $display("test page_write done");
    fill(8'ha0);
    wr(7'h0e, 6);
    rd(7'h0c, 4);
    for (int i = 0; i < 4; i++) check(rbuf[i], 8'ha2 + 8'(i));
    $display("test page_wrap done");
    fill(8'hc0);
    wr(7'h00, 1);
    fill(8'hb0);
    wr(7'h7f, 1);
    rd(7'h7f, 2);
    check(rbuf[0], 8'hb0);
    check(rbuf[1], 8'hc0);
    $display("test read_wrap done");
    test_done();
  end
  // Whole run needs about three and a half thousand cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    $display("watchdog expired");
    test_done();
  end
endmodule
`default_nettype wire
